// >>> pin_event_interrupt_logic.sv
// Purpose: Pin channels, pattern engine and two grouped interrupt units
// Assumes: Pins asynchronous, register port single cycle
// Notes:   Pattern mode replaces channel requests with product terms
`timescale 1ns/1ps

module pin_event_interrupt_logic #(
  parameter int N_PINS = 32            // Digital pins offered
) (
  input  wire logic              I_MCLK,     // System clock
  input  wire logic              I_RESET_N,  // Sync reset, active low
  input  wire logic [N_PINS-1:0] I_PINS,     // Digital input pins
  input  wire logic              I_SLEEP,    // Part in power saving
  input  wire logic [7:0]        I_ADDR,     // Register byte address
  input  wire logic [31:0]       I_WDATA,    // Write data
  input  wire logic              I_WR,       // Write strobe
  input  wire logic              I_RD,       // Read strobe
  output logic      [31:0]       O_RDATA,    // Read data, next cycle
  output logic      [7:0]        O_PIN_IRQ,  // Channel or term requests
  output logic      [1:0]        O_GRP_IRQ,  // Group requests
  output logic                   O_EVENT,    // CPU event notify pulse
  output logic                   O_WAKE      // Wake request
);
  localparam int NC = pel_pkg::NUM_CH;       // Channel count
  localparam int FW = pel_pkg::PM_FW;        // Pattern field width

  // Refuse pin counts the select fields cannot reach
  if (N_PINS < NC || N_PINS > 32) begin : g_chk
    $error("N_PINS must lie between 8 and 32");
  end

  // Synchroniser and channel inputs
  logic [N_PINS-1:0]        meta;       // First synchroniser stage
  logic [N_PINS-1:0]        pins;       // Synchronised pins
  logic [NC-1:0]            chan_now;   // Selected pin per channel
  logic [NC-1:0]            chan_prev;  // Previous selected pin
  logic [NC-1:0]            rise;       // Rising edge per channel
  logic [NC-1:0]            fall;       // Falling edge per channel

  // Channel configuration and state
  logic [pel_pkg::SEL_W-1:0] sel [NC];  // Pin select per channel
  logic [NC-1:0]            ch_level;   // Level mode
  logic [NC-1:0]            ch_hi;      // Rise enable or level enable
  logic [NC-1:0]            ch_lo;      // Fall enable or low active
  logic [NC-1:0]            ch_stat;    // Edge status flags
  logic [NC-1:0]            ch_wake;    // Wake enables
  logic [NC-1:0]            ch_set;     // Edge events this cycle
  logic [NC-1:0]            ch_lvl;     // Level requests
  logic [NC-1:0]            ch_req;     // Channel request per mode

  // Pattern engine
  logic [FW-1:0]            pm_src [NC];  // Slice input channel
  pel_pkg::pm_cond_t        pm_cond [NC]; // Slice condition
  logic [NC-1:0]            pm_end;     // Slice ends a product term
  logic                     pm_on;      // Engine replaces channels
  logic                     ev_on;      // Event notify enable
  logic [NC-1:0]            pm_b;       // Slice pin now
  logic [NC-1:0]            pm_bp;      // Slice pin before
  logic [NC-1:0]            pm_rise;    // Sticky rise per slice
  logic [NC-1:0]            pm_fall;    // Sticky fall per slice
  logic [NC-1:0]            terms;      // Product terms by endpoint
  logic [NC-1:0]            term_q;     // Terms one cycle ago
  logic [NC-1:0]            new_term;   // Terms becoming true
  logic                     acc;        // Running product
  logic                     tv;         // Slice truth value

  // Group configuration
  logic [N_PINS-1:0]        grp_ena [2];  // Per-pin enable
  logic [N_PINS-1:0]        grp_pol [2];  // Per-pin polarity
  logic [1:0]               grp_and;      // AND combine
  logic [1:0]               grp_lvl;      // Level triggered
  logic [1:0]               grp_stat;     // Status from units
  logic [1:0]               grp_wake;     // Wake from units

  // Register port decode
  logic [31:0]              rd_mux;     // Read value before register
  logic                     wr_sel_lo;  // Write select low word
  logic                     wr_sel_hi;  // Write select high word
  logic                     wr_mode;    // Write channel mode
  logic                     wr_hi;      // Write rise/level enable
  logic                     wr_lo;      // Write fall/low active
  logic                     wr_stat;    // Write channel status
  logic                     wr_wake;    // Write wake enables
  logic                     wr_src;     // Write slice selects
  logic                     wr_cond;    // Write slice conditions
  logic                     wr_pm;      // Write pattern control
  logic [1:0]               wr_gctl;    // Write group control
  logic [1:0]               wr_gpol;    // Write group polarity
  logic [1:0]               wr_gena;    // Write group enable
  logic [NC-1:0]            stat_clr;   // Channel status clear mask
  logic                     pm_clr;     // Sticky flags clear
  logic                     next_wake;  // Next wake value

  assign wr_sel_lo = I_WR && (I_ADDR == pel_pkg::SEL_LO_OFS);
  assign wr_sel_hi = I_WR && (I_ADDR == pel_pkg::SEL_HI_OFS);
  assign wr_mode   = I_WR && (I_ADDR == pel_pkg::CH_MODE_OFS);
  assign wr_hi     = I_WR && (I_ADDR == pel_pkg::CH_HI_OFS);
  assign wr_lo     = I_WR && (I_ADDR == pel_pkg::CH_LO_OFS);
  assign wr_stat   = I_WR && (I_ADDR == pel_pkg::CH_STAT_OFS);
  assign wr_wake   = I_WR && (I_ADDR == pel_pkg::CH_WAKE_OFS);
  assign wr_src    = I_WR && (I_ADDR == pel_pkg::PM_SRC_OFS);
  assign wr_cond   = I_WR && (I_ADDR == pel_pkg::PM_COND_OFS);
  assign wr_pm     = I_WR && (I_ADDR == pel_pkg::PM_CTRL_OFS);
  assign stat_clr  = wr_stat ? I_WDATA[NC-1:0] : '0;
  assign pm_clr    = wr_src || wr_cond || wr_pm;

  // Two-flop synchroniser; only the second stage is looked at
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      meta <= '0;
      pins <= '0;
    end else begin
      meta <= I_PINS;
      pins <= meta;
    end
  end

  // Channel pin selection and edge detection
  for (genvar c = 0; c < NC; c++) begin : g_ch
    assign chan_now[c] = (int'(sel[c]) < N_PINS) ? pins[sel[c]] : 1'b0;
    assign pm_b[c]     = chan_now[pm_src[c]];
    assign pm_bp[c]    = chan_prev[pm_src[c]];
  end
  assign rise   = chan_now & ~chan_prev;
  assign fall   = ~chan_now & chan_prev;
  assign ch_set = ~ch_level & ((rise & ch_hi) | (fall & ch_lo));
  assign ch_lvl = ch_level & ch_hi & (chan_now ^ ch_lo);
  assign ch_req = ch_lvl | (ch_stat & ~ch_level);

  // Channel select and mode registers
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      for (int c = 0; c < NC; c++) sel[c] <= '0;
      ch_level <= pel_pkg::REG_RST[NC-1:0];
      ch_hi    <= pel_pkg::REG_RST[NC-1:0];
      ch_lo    <= pel_pkg::REG_RST[NC-1:0];
      ch_wake  <= pel_pkg::REG_RST[NC-1:0];
    end else begin
      for (int c = 0; c < NC / 2; c++) begin
        if (wr_sel_lo) begin
          sel[c] <= I_WDATA[c*pel_pkg::SEL_FW +: pel_pkg::SEL_W];
        end
        if (wr_sel_hi) begin
          sel[c+NC/2] <= I_WDATA[c*pel_pkg::SEL_FW +: pel_pkg::SEL_W];
        end
      end
      if (wr_mode) ch_level <= I_WDATA[NC-1:0];
      if (wr_hi)   ch_hi    <= I_WDATA[NC-1:0];
      if (wr_lo)   ch_lo    <= I_WDATA[NC-1:0];
      if (wr_wake) ch_wake  <= I_WDATA[NC-1:0];
    end
  end

  // Edge status: a new edge wins over a clear in the same cycle
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      chan_prev <= '0;
      ch_stat   <= '0;
    end else begin
      chan_prev <= chan_now;
      ch_stat   <= ch_set | (ch_stat & ~stat_clr);
    end
  end

  // Pattern engine configuration
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      for (int s = 0; s < NC; s++) begin
        pm_src[s]  <= '0;
        pm_cond[s] <= pel_pkg::PM_ALWAYS;
      end
      pm_end <= '0;
      pm_on  <= 1'b0;
      ev_on  <= 1'b0;
    end else begin
      for (int s = 0; s < NC; s++) begin
        if (wr_src)  pm_src[s]  <= I_WDATA[s*FW +: FW];
        if (wr_cond) pm_cond[s] <= pel_pkg::pm_cond_t'(I_WDATA[s*FW +: FW]);
      end
      if (wr_pm) begin
        pm_end <= I_WDATA[NC-1:0];
        pm_on  <= I_WDATA[pel_pkg::PM_ON_BIT];
        ev_on  <= I_WDATA[pel_pkg::PM_EV_BIT];
      end
    end
  end

  // Sticky slice flags; a reconfiguration restarts them
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      pm_rise <= '0;
      pm_fall <= '0;
      term_q  <= '0;
    end else begin
      pm_rise <= (pm_rise & ~{NC{pm_clr}}) | (pm_b & ~pm_bp);
      pm_fall <= (pm_fall & ~{NC{pm_clr}}) | (~pm_b & pm_bp);
      term_q  <= terms;
    end
  end

  // Sum of products: slices AND together up to each endpoint
  always_comb begin
    acc   = 1'b1;
    tv    = 1'b0;
    terms = '0;
    for (int s = 0; s < NC; s++) begin
      case (pm_cond[s])
        pel_pkg::PM_ALWAYS:   tv = 1'b1;
        pel_pkg::PM_HIGH:     tv = pm_b[s];
        pel_pkg::PM_LOW:      tv = !pm_b[s];
        pel_pkg::PM_ST_RISE:  tv = pm_rise[s] || (pm_b[s] && !pm_bp[s]);
        pel_pkg::PM_ST_FALL:  tv = pm_fall[s] || (!pm_b[s] && pm_bp[s]);
        pel_pkg::PM_ST_EDGE:  tv = pm_rise[s] || pm_fall[s] ||
                                   (pm_b[s] != pm_bp[s]);
        pel_pkg::PM_EDGE_NOW: tv = pm_b[s] != pm_bp[s];
        default:              tv = 1'b0;
      endcase
      acc = acc && tv;
      if (pm_end[s]) begin
        terms[s] = acc;
        acc      = 1'b1;
      end
    end
  end
  assign new_term = terms & ~term_q;

  // Wake: channels and groups only, never the pattern engine
  assign next_wake = (I_SLEEP && !pm_on && |(ch_req & ch_wake))
                     || (|grp_wake);

  // Request, event and wake outputs
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      O_PIN_IRQ <= '0;
      O_EVENT   <= 1'b0;
      O_WAKE    <= 1'b0;
    end else begin
      O_PIN_IRQ <= pm_on ? terms : ch_req;
      O_EVENT   <= pm_on && ev_on && |new_term;
      O_WAKE    <= next_wake;
    end
  end

  // Grouped interrupt units
  grp_bus_if #(.N(N_PINS)) gbus [2] ();
  for (genvar g = 0; g < 2; g++) begin : g_grp
    localparam logic [7:0] GOFS = 8'(g) * pel_pkg::GRP_STRIDE;
    assign wr_gctl[g] = I_WR && (I_ADDR == pel_pkg::GRP_CTRL_OFS + GOFS);
    assign wr_gpol[g] = I_WR && (I_ADDR == pel_pkg::GRP_POL_OFS + GOFS);
    assign wr_gena[g] = I_WR && (I_ADDR == pel_pkg::GRP_ENA_OFS + GOFS);
    assign gbus[g].ena      = grp_ena[g];
    assign gbus[g].pol      = grp_pol[g];
    assign gbus[g].pins     = pins;
    assign gbus[g].raw      = I_PINS;
    assign gbus[g].and_mode = grp_and[g];
    assign gbus[g].lvl_mode = grp_lvl[g];
    assign gbus[g].clr      = wr_gctl[g] && I_WDATA[pel_pkg::GRP_STAT_BIT];
    assign gbus[g].sleep    = I_SLEEP;
    assign grp_stat[g]      = gbus[g].stat;
    assign grp_wake[g]      = gbus[g].wake;

    // Group configuration registers
    always_ff @(posedge I_MCLK) begin
      if (!I_RESET_N) begin
        grp_ena[g] <= '0;
        grp_pol[g] <= '0;
        grp_and[g] <= 1'b0;
        grp_lvl[g] <= 1'b0;
      end else begin
        if (wr_gena[g]) grp_ena[g] <= I_WDATA[N_PINS-1:0];
        if (wr_gpol[g]) grp_pol[g] <= I_WDATA[N_PINS-1:0];
        if (wr_gctl[g]) begin
          grp_and[g] <= I_WDATA[pel_pkg::GRP_AND_BIT];
          grp_lvl[g] <= I_WDATA[pel_pkg::GRP_LVL_BIT];
        end
      end
    end
  end
  assign O_GRP_IRQ = grp_stat;

  group_irq_unit #(.N(N_PINS)) group_irq_unit_a (
    .I_MCLK    (I_MCLK),
    .I_RESET_N (I_RESET_N),
    .bus       (gbus[0])
  );
  group_irq_unit #(.N(N_PINS)) group_irq_unit_b (
    .I_MCLK    (I_MCLK),
    .I_RESET_N (I_RESET_N),
    .bus       (gbus[1])
  );

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    if (I_ADDR == pel_pkg::SEL_LO_OFS) begin
      for (int c = 0; c < NC / 2; c++)
        rd_mux[c*pel_pkg::SEL_FW +: pel_pkg::SEL_W] = sel[c];
    end else if (I_ADDR == pel_pkg::SEL_HI_OFS) begin
      for (int c = 0; c < NC / 2; c++)
        rd_mux[c*pel_pkg::SEL_FW +: pel_pkg::SEL_W] = sel[c+NC/2];
    end else if (I_ADDR == pel_pkg::CH_MODE_OFS) begin
      rd_mux[NC-1:0] = ch_level;
    end else if (I_ADDR == pel_pkg::CH_HI_OFS) begin
      rd_mux[NC-1:0] = ch_hi;
    end else if (I_ADDR == pel_pkg::CH_LO_OFS) begin
      rd_mux[NC-1:0] = ch_lo;
    end else if (I_ADDR == pel_pkg::CH_STAT_OFS) begin
      rd_mux[NC-1:0] = ch_req;
    end else if (I_ADDR == pel_pkg::CH_WAKE_OFS) begin
      rd_mux[NC-1:0] = ch_wake;
    end else if (I_ADDR == pel_pkg::PM_SRC_OFS) begin
      for (int s = 0; s < NC; s++) rd_mux[s*FW +: FW] = pm_src[s];
    end else if (I_ADDR == pel_pkg::PM_COND_OFS) begin
      for (int s = 0; s < NC; s++) rd_mux[s*FW +: FW] = pm_cond[s];
    end else if (I_ADDR == pel_pkg::PM_CTRL_OFS) begin
      rd_mux[NC-1:0]              = pm_end;
      rd_mux[pel_pkg::PM_ON_BIT] = pm_on;
      rd_mux[pel_pkg::PM_EV_BIT] = ev_on;
    end else if (I_ADDR == pel_pkg::PM_TERM_OFS) begin
      rd_mux[NC-1:0] = terms;
    end else begin
      for (int g = 0; g < 2; g++) begin
        if (I_ADDR == pel_pkg::GRP_CTRL_OFS + 8'(g) * pel_pkg::GRP_STRIDE)
        begin
          rd_mux[pel_pkg::GRP_STAT_BIT] = grp_stat[g];
          rd_mux[pel_pkg::GRP_AND_BIT]  = grp_and[g];
          rd_mux[pel_pkg::GRP_LVL_BIT]  = grp_lvl[g];
        end
        if (I_ADDR == pel_pkg::GRP_POL_OFS + 8'(g) * pel_pkg::GRP_STRIDE)
          rd_mux[N_PINS-1:0] = grp_pol[g];
        if (I_ADDR == pel_pkg::GRP_ENA_OFS + 8'(g) * pel_pkg::GRP_STRIDE)
          rd_mux[N_PINS-1:0] = grp_ena[g];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      O_RDATA <= '0;
    end else begin
      O_RDATA <= I_RD ? rd_mux : '0;
    end
  end

  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);

  AST_SYNC_TWO: assert property (
    $stable(I_PINS) [*3] |-> pins == I_PINS)
    else $error("pins not synchronised in two cycles");
  AST_RD_NEXT: assert property (
    I_RD |=> O_RDATA == $past(rd_mux))
    else $error("read data not in next cycle");
  AST_EDGE_IRQ: assert property (
    !pm_on && !ch_level[0] && ch_hi[0] && rise[0] ##1 !pm_on
    |=> O_PIN_IRQ[0])
    else $error("rising edge missed on channel 0");
  AST_LVL_IRQ: assert property (
    !pm_on && ch_level[1] && ch_hi[1] && (chan_now[1] ^ ch_lo[1])
    |=> O_PIN_IRQ[1])
    else $error("level request missing on channel 1");
  AST_EVENT_PULSE: assert property (
    O_EVENT |-> $past(ev_on) && $past(pm_on) &&
    ($past(new_term) != 0))
    else $error("event without enabled match");
  AST_NO_PM_WAKE: assert property (
    pm_on && grp_wake == 2'b00 ##1 pm_on |=> !O_WAKE || $past(|grp_wake))
    else $error("pattern engine raised wake");
  AST_CH_WAKE: assert property (
    I_SLEEP && !pm_on && |(ch_req & ch_wake) |=> O_WAKE)
    else $error("channel wake missing");

  CV_PM_TERM:  cover property (pm_on && $rose(O_PIN_IRQ[7]));
  CV_EVENT:    cover property (O_EVENT);
  CV_GRP_WAKE: cover property (I_SLEEP && $rose(O_WAKE) ##[1:4] O_GRP_IRQ[0]);
endmodule : pin_event_interrupt_logic

// >>> pel_pkg.sv
// Purpose: Shared constants for the pin event interrupt logic
// Assumes: 8-bit byte address, 32-bit register words
// Notes:   All configuration resets to zero
package pel_pkg;
  localparam int          NUM_CH       = 8;      // Pin channels
  localparam int          SEL_W        = 5;      // Pin select width
  localparam int          SEL_FW       = 8;      // Select field stride
  localparam int          PM_FW        = 3;      // Pattern field width
  localparam int          ADDR_W       = 8;      // Register address bits
  localparam logic [7:0]  SEL_LO_OFS   = 8'h00;  // Selects, channels 0-3
  localparam logic [7:0]  SEL_HI_OFS   = 8'h04;  // Selects, channels 4-7
  localparam logic [7:0]  CH_MODE_OFS  = 8'h08;  // 1 = level, 0 = edge
  localparam logic [7:0]  CH_HI_OFS    = 8'h0c;  // Rise enable / level on
  localparam logic [7:0]  CH_LO_OFS    = 8'h10;  // Fall enable / low active
  localparam logic [7:0]  CH_STAT_OFS  = 8'h14;  // Status, write 1 clears
  localparam logic [7:0]  CH_WAKE_OFS  = 8'h18;  // Wake enables
  localparam logic [7:0]  PM_SRC_OFS   = 8'h1c;  // Slice input selects
  localparam logic [7:0]  PM_COND_OFS  = 8'h20;  // Slice conditions
  localparam logic [7:0]  PM_CTRL_OFS  = 8'h24;  // Endpoints and enables
  localparam logic [7:0]  PM_TERM_OFS  = 8'h28;  // Live product terms
  localparam logic [7:0]  GRP_CTRL_OFS = 8'h30;  // Group control, unit a
  localparam logic [7:0]  GRP_POL_OFS  = 8'h34;  // Group polarity, unit a
  localparam logic [7:0]  GRP_ENA_OFS  = 8'h38;  // Group enable, unit a
  localparam logic [7:0]  GRP_STRIDE   = 8'h10;  // Unit b follows unit a
  localparam int          PM_ON_BIT    = 8;      // Pattern engine on
  localparam int          PM_EV_BIT    = 9;      // Event notify enable
  localparam int          GRP_STAT_BIT = 0;      // Request status, W1C
  localparam int          GRP_AND_BIT  = 1;      // 1 = AND, 0 = OR
  localparam int          GRP_LVL_BIT  = 2;      // 1 = level, 0 = edge
  localparam logic [31:0] REG_RST      = 32'h0;  // Reset value of registers

  // Slice conditions of the pattern engine
  typedef enum logic [2:0] {
    PM_ALWAYS   = 3'h0,  // Constant true
    PM_HIGH     = 3'h1,  // Pin high now
    PM_LOW      = 3'h2,  // Pin low now
    PM_ST_RISE  = 3'h3,  // Rise seen since cleared
    PM_ST_FALL  = 3'h4,  // Fall seen since cleared
    PM_ST_EDGE  = 3'h5,  // Any edge seen since cleared
    PM_EDGE_NOW = 3'h6,  // Edge in this cycle
    PM_NEVER    = 3'h7   // Constant false
  } pm_cond_t;
endpackage : pel_pkg

// >>> grp_bus_if.sv
// Purpose: Carries one group unit's configuration and status
// Assumes: Pins already visible in both raw and synchronised form
// Notes:   One instance per group unit
`timescale 1ns/1ps
interface grp_bus_if #(parameter int N = 32);
  logic [N-1:0] ena;       // Per-pin enable
  logic [N-1:0] pol;       // Per-pin polarity, 1 = active high
  logic [N-1:0] pins;      // Synchronised pins
  logic [N-1:0] raw;       // Unsynchronised pins for wake
  logic         and_mode;  // Combine by AND
  logic         lvl_mode;  // Level triggered
  logic         clr;       // Clear strobe
  logic         sleep;     // Part in power saving mode
  logic         stat;      // Request status
  logic         wake;      // Wake request
  modport unit (input ena, pol, pins, raw, and_mode, lvl_mode, clr, sleep,
                output stat, wake);
  modport ctl  (output ena, pol, pins, raw, and_mode, lvl_mode, clr, sleep,
                input stat, wake);
endinterface : grp_bus_if

// >>> group_irq_unit.sv
// Purpose: One grouped pin interrupt unit
// Assumes: Clear strobe is one cycle long
// Notes:   Wake runs from raw pins so it leads the request
`timescale 1ns/1ps
module group_irq_unit #(parameter int N = 32) (
  input wire logic I_MCLK,     // System clock
  input wire logic I_RESET_N,  // Synchronous reset, active low
  grp_bus_if.unit  bus         // Configuration and status
);
  logic hit_s;    // Pattern on synchronised pins
  logic hit_r;    // Pattern on raw pins
  logic hit_q;    // Previous synchronised pattern
  logic set;      // Status set condition

  // Combine enabled, polarity adjusted inputs; the settings come in as
  // arguments so the assigns below re-evaluate when software writes them
  function automatic logic hit(input logic [N-1:0] p,
                               input logic [N-1:0] pol,
                               input logic [N-1:0] ena,
                               input logic         and_mode);
    logic [N-1:0] act;
    act = ~(p ^ pol);
    if (and_mode) begin
      hit = (|ena) && (&(act | ~ena));
    end else begin
      hit = |(act & ena);
    end
  endfunction : hit

  assign hit_s = hit(bus.pins, bus.pol, bus.ena, bus.and_mode);
  assign hit_r = hit(bus.raw, bus.pol, bus.ena, bus.and_mode);
  assign set   = bus.lvl_mode ? hit_s : (hit_s && !hit_q);

  // Status: set wins over software clear
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      hit_q    <= 1'b0;
      bus.stat <= 1'b0;
      bus.wake <= 1'b0;
    end else begin
      hit_q    <= hit_s;
      bus.stat <= set || (bus.stat && !bus.clr);
      bus.wake <= bus.sleep && hit_r;
    end
  end

  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);

  AST_GRP_EDGE: assert property (
    !bus.lvl_mode && hit_s && !hit_q |=> bus.stat)
    else $error("group edge not latched");
  AST_GRP_CLR: assert property (
    bus.clr && !set |=> !bus.stat)
    else $error("group clear ignored");
  AST_GRP_WAKE: assert property (
    bus.sleep && hit_r && !hit_s && !bus.stat |=> bus.wake && !bus.stat)
    else $error("wake did not lead request");
  CV_GRP_AND: cover property (bus.and_mode && $rose(bus.stat));
endmodule : group_irq_unit

// >>> pin_source.sv
// Purpose: Outside pins feeding the pin event logic
// Assumes: Bench requests levels, model moves the pins
// Notes:   Pins change mid-cycle, so they are asynchronous to the clock
`timescale 1ns/1ps
module pin_source (
  input  wire logic        I_MCLK,  // System clock
  input  wire logic [31:0] i_want,  // Requested pin levels
  output logic      [31:0] o_pins   // Levels seen at the pins
);
  initial o_pins = 32'h0;
  // Pins settle 30 ns after an edge, away from the sampling point
  always @(posedge I_MCLK) begin
    o_pins <= #30 i_want;
  end
endmodule : pin_source

// >>> pin_event_interrupt_logic_tb.sv
// Purpose: Self-checking bench for the pin event interrupt logic
// Assumes: Single-cycle register port, outside pins from pin_source
// Notes:   Waits are bounded loops or fixed settle spans
`timescale 1ns/1ps
module pin_event_interrupt_logic_tb;
  logic I_MCLK = 0, I_RESET_N = 0, I_SLEEP = 0, I_WR = 0, I_RD = 0;
  logic [7:0]  I_ADDR = 8'h0;   // Register address
  logic [31:0] I_WDATA = 32'h0, want = 32'h0, O_RDATA;
  wire  [31:0] I_PINS;          // Pins from the model
  logic [7:0]  O_PIN_IRQ;       // Channel or term requests
  logic [1:0]  O_GRP_IRQ;       // Group requests
  logic        O_EVENT, O_WAKE; // Event pulse and wake
  int          n_fail = 0, comparisons = 0, k;
  always #50 I_MCLK = ~I_MCLK;
  pin_source u_pin_source (.I_MCLK(I_MCLK), .i_want(want), .o_pins(I_PINS));
  pin_event_interrupt_logic u_pin_event_interrupt_logic (.I_MCLK(I_MCLK),
    .I_RESET_N(I_RESET_N), .I_PINS(I_PINS), .I_SLEEP(I_SLEEP),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(O_RDATA), .O_PIN_IRQ(O_PIN_IRQ), .O_GRP_IRQ(O_GRP_IRQ),
    .O_EVENT(O_EVENT), .O_WAKE(O_WAKE));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge I_MCLK);
    #1;
  endtask : tick
  // One-cycle write strobe
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_MCLK) {I_WR, I_ADDR, I_WDATA} <= {1'h1, a, d};
    @(posedge I_MCLK) I_WR <= 1'h0;
  endtask : wr
  // Read strobe, data checked in the following cycle
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge I_MCLK) {I_RD, I_ADDR} <= {1'h1, a};
    @(posedge I_MCLK) I_RD <= 1'h0;
    #1 chk("rdata", O_RDATA, exp);
  endtask : rd
  task end_sim;
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (3000) @(posedge I_MCLK);
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge I_MCLK);
    I_RESET_N <= 1'h1;
    tick(1);
    chk("idle", {O_PIN_IRQ, O_GRP_IRQ, O_EVENT, O_WAKE}, 32'h0);
    // Ch0 on pin 3 rising edge, ch1 on pin 5 level low
    wr(pel_pkg::SEL_LO_OFS, 32'h0503);
    wr(pel_pkg::CH_MODE_OFS, 32'h2);
    wr(pel_pkg::CH_HI_OFS, 32'h3);
    wr(pel_pkg::CH_LO_OFS, 32'h2);
    rd(pel_pkg::CH_HI_OFS, 32'h3);
    rd(8'h2c, 32'h0);
    tick(4);
    chk("low", O_PIN_IRQ, 32'h2);
    want = 32'h28;
    tick(6);
    chk("rise", O_PIN_IRQ, 32'h1);
    wr(pel_pkg::CH_STAT_OFS, 32'h1);
    tick(3);
    chk("clr", O_PIN_IRQ, 32'h0);
    want = 32'h20;
    tick(6);
    chk("nofall", O_PIN_IRQ, 32'h0);
    // Channel wake while asleep
    wr(pel_pkg::CH_WAKE_OFS, 32'h1);
    @(posedge I_MCLK) I_SLEEP <= 1'h1;
    want <= 32'h28;
    for (k = 0; k < 8 && O_WAKE !== 1'h1; k++) tick(1);
    chk("chwake", O_WAKE, 32'h1);
    wr(pel_pkg::CH_WAKE_OFS, 32'h0);
    wr(pel_pkg::CH_STAT_OFS, 32'h1);
    // Group a: pin 7 high, OR, edge; polarity before enable
    want <= 32'h0;
    wr(pel_pkg::GRP_POL_OFS, 32'h80);
    wr(pel_pkg::GRP_ENA_OFS, 32'h80);
    wr(pel_pkg::GRP_CTRL_OFS, 32'h0);
    tick(4);
    want = 32'h80;
    for (k = 0; k < 8 && !O_WAKE && !O_GRP_IRQ[0]; k++) tick(1);
    chk("wakefirst", {O_WAKE, O_GRP_IRQ[0]}, 32'h2);
    tick(4);
    chk("grpa", O_GRP_IRQ[0], 32'h1);
    wr(pel_pkg::GRP_CTRL_OFS, 32'h1);
    tick(3);
    chk("grpclr", O_GRP_IRQ, 32'h0);
    // Group b: pins 5 low and 7 high, AND, level; enable written last
    wr(pel_pkg::GRP_POL_OFS + pel_pkg::GRP_STRIDE, 32'h80);
    wr(pel_pkg::GRP_CTRL_OFS + pel_pkg::GRP_STRIDE, 32'h6);
    wr(pel_pkg::GRP_ENA_OFS + pel_pkg::GRP_STRIDE, 32'ha0);
    tick(5);
    chk("and", O_GRP_IRQ, 32'h2);
    want = 32'ha0;
    tick(5);
    chk("andhold", O_GRP_IRQ, 32'h2);
    wr(pel_pkg::GRP_CTRL_OFS + pel_pkg::GRP_STRIDE, 32'h7);
    tick(3);
    chk("andoff", O_GRP_IRQ, 32'h0);
    // Pattern: one slice, ch0 pin high, event on, still asleep
    want = 32'h0;
    wr(pel_pkg::PM_SRC_OFS, 32'h0);
    wr(pel_pkg::PM_COND_OFS, 32'h1);
    wr(pel_pkg::PM_CTRL_OFS, 32'h301);
    tick(4);
    want = 32'h08;
    for (k = 0; k < 8 && O_EVENT !== 1'h1; k++) tick(1);
    chk("event", O_EVENT, 32'h1);
    tick(1);
    chk("evpulse", O_EVENT, 32'h0);
    chk("term", O_PIN_IRQ[0], 32'h1);
    chk("nowake", O_WAKE, 32'h0);
    end_sim();
  end
endmodule : pin_event_interrupt_logic_tb
